// ===== rtl/adc_pkg.sv
package adc_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_RES_LOW = 8'h00;
  localparam logic [7:0] OFF_RES_HIGH = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_CLK_PWR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  // converter_control fields
  localparam int unsigned CTL_START_BIT = 7;
  localparam int unsigned CTL_DONE_N_BIT = 6;
  localparam int unsigned CTL_PCR_LSB = 3;
  localparam int unsigned CTL_ACS_LSB = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'hBF;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // converter_clock_power fields
  localparam int unsigned CSP_PD_BIT = 7;
  localparam int unsigned CSP_DIV_LSB = 0;
  localparam logic [7:0] CSP_WR_MASK = 8'h87;
  localparam logic [7:0] CSP_RESET = 8'h80;
  // conversion timing and pin config
  localparam int unsigned CONV_TICKS = 16;
  localparam logic [2:0] PCR_ALL = 3'h7;
  localparam logic [2:0] PCR_NONE = 3'h0;
  localparam int unsigned RES_W = 12;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RESET = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_t;

  // system clock cycles per conversion clock period; zero means undefined
  function automatic logic [5:0] div_ratio(input logic [2:0] sel);
    logic [5:0] r;
    r = 6'h00;
    unique case (sel)
      3'h0: r = 6'h02;
      3'h1: r = 6'h08;
      3'h2: r = 6'h20;
      default: r = 6'h00;
    endcase
    return r;
  endfunction
endpackage

// ===== rtl/conv_link_if.sv
`timescale 1ns/1ps
interface conv_link_if;
  logic start;
  logic on;
  logic [2:0] div_sel;
  logic run;
  logic tick;
  logic conv_clk;
  logic eoc;
  logic done;
  logic conv_rst;

  modport top (
    output start, on, div_sel,
    input eoc, done, conv_rst, conv_clk
  );
  modport seq (
    input start, on, div_sel, tick,
    output run, eoc, done, conv_rst
  );
  modport div (
    input run, div_sel,
    output tick, conv_clk
  );
endinterface

// ===== rtl/conv_clock_div.sv
`timescale 1ns/1ps
module conv_clock_div #(
  parameter int unsigned CNT_W = 5
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // sequencer side
  conv_link_if.div link
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic clk_q, clk_d;
  logic [5:0] ratio;
  logic last;

  // count is held at zero outside a conversion so every one starts on a full period
  always_comb
  begin
    ratio = adc_pkg::div_ratio(link.div_sel);
    last = (ratio != 6'h00) && (cnt_q == CNT_W'(ratio - 6'h01));
    cnt_d = cnt_q;
    if (!link.run || ratio == 6'h00 || last)
    begin
      cnt_d = '0;
    end
    else
    begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    // high for the first half of each period, so a conversion shows exactly sixteen rises
    clk_d = link.run && (ratio != 6'h00) && ({1'b0, cnt_q} < (ratio >> 1));
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign link.tick = link.run && last;
  assign link.conv_clk = clk_q;
endmodule // conv_clock_div

// ===== rtl/conv_sequencer.sv
`timescale 1ns/1ps
module conv_sequencer #(
  parameter int unsigned CONV_TICKS = adc_pkg::CONV_TICKS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // divider and register side
  conv_link_if.seq link
);
  localparam int unsigned CW = $clog2(CONV_TICKS);
  localparam logic [CW-1:0] LAST = CW'(CONV_TICKS - 1);

  adc_pkg::seq_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic eoc_q, eoc_d;
  logic done_q, done_d;
  logic crst_q, crst_d;
  logic [9:0] cyc_q, cyc_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    eoc_d = eoc_q;
    done_d = 1'b0;
    unique case (state_q)
      adc_pkg::SEQ_IDLE:
      begin
        if (link.start)
        begin
          state_d = adc_pkg::SEQ_RESET;
          eoc_d = 1'b1;
        end
      end
      adc_pkg::SEQ_RESET:
      begin
        eoc_d = 1'b1;
        if (!link.start)
        begin
          state_d = adc_pkg::SEQ_CONV;
          cnt_d = '0;
        end
      end
      adc_pkg::SEQ_CONV:
      begin
        if (link.start)
        begin
          state_d = adc_pkg::SEQ_RESET;
          eoc_d = 1'b1;
        end
        else if (link.tick)
        begin
          if (cnt_q == LAST)
          begin
            state_d = adc_pkg::SEQ_IDLE;
            eoc_d = 1'b0;
            done_d = 1'b1;
          end
          else
          begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      default:
      begin
        state_d = adc_pkg::SEQ_IDLE;
      end
    endcase
    // converter held in reset while armed and whenever it is unpowered
    crst_d = (state_d == adc_pkg::SEQ_RESET) || !link.on;
    cyc_d = (state_q == adc_pkg::SEQ_CONV && link.run) ? cyc_q + 10'h001 : 10'h000;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= adc_pkg::SEQ_IDLE;
      cnt_q <= '0;
      eoc_q <= 1'b1;
      done_q <= 1'b0;
      crst_q <= 1'b1;
      cyc_q <= 10'h000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      eoc_q <= eoc_d;
      done_q <= done_d;
      crst_q <= crst_d;
      cyc_q <= cyc_d;
    end
  end

  // an unpowered converter stalls the count instead of aborting it
  assign link.run = (state_q == adc_pkg::SEQ_CONV) && link.on;
  assign link.eoc = eoc_q;
  assign link.done = done_q;
  assign link.conv_rst = crst_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_arm;
    state_q == adc_pkg::SEQ_IDLE && link.start;
  endsequence
  sequence s_armed;
    state_q == adc_pkg::SEQ_RESET && link.eoc && link.conv_rst;
  endsequence
  sequence s_release;
    state_q == adc_pkg::SEQ_RESET && !link.start;
  endsequence

  a_start_resets: assert property (s_arm |=> s_armed)
    else $error("raising start did not reset converter");
  a_pulse_starts: assert property (s_release |=> state_q == adc_pkg::SEQ_CONV && link.eoc)
    else $error("falling start did not begin conversion");
  a_done_clears: assert property (link.done |-> !link.eoc && $past(state_q) == adc_pkg::SEQ_CONV)
    else $error("end of conversion flag not cleared at done");
  a_conv_length: assert property (
    (state_q == adc_pkg::SEQ_CONV && state_d == adc_pkg::SEQ_IDLE)
      |-> cyc_q == 10'(CONV_TICKS * adc_pkg::div_ratio(link.div_sel) - 1))
    else $error("conversion length not sixteen conversion clocks");
endmodule // conv_sequencer

// ===== rtl/adc_sequencing_control.sv
`timescale 1ns/1ps
// Contract
// - result bits 11..4 fill the whole result high byte
// - result bits 3..0 sit in bits 7..4 of result low byte
// - 3-bit channel select routes one of eight inputs to the converter
// - pin config 111 makes all eight shared pins analog inputs
// - pin config zero leaves pins digital and powers converter off
// - converter powered only with power-down 0 and non-zero pin config
// - start pulsed 0-1-0 by software begins one conversion
// - while start is high converter is reset and done_n flag forced 1
// - done_n flag clears to 0 when a conversion finishes
// - each conversion end sets interrupt flag; enabled flag raises interrupt
// - divider field 000 /2, 001 /8, 010 /32, 011 undefined
// - one conversion lasts sixteen conversion clock periods
// - analog pins override port direction and drop pull-high resistors; this block only drives analog_pin_en_o for the port logic
module adc_sequencing_control (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // converter macro
  input wire logic [11:0] sar_data_i,
  output logic [2:0] channel_sel_o,
  output logic conv_power_o,
  output logic conv_reset_o,
  output logic conv_clk_o,
  // shared port pins
  output logic [7:0] analog_pin_en_o,
  // interrupt
  output logic irq_o
);
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] csp_q, csp_d;
  logic [11:0] res_q, res_d;
  logic sts_q, sts_d;
  logic ien_q, ien_d;
  logic irq_q, irq_d;
  logic [11:0] sar_s1_q, sar_s2_q;
  logic wr_q, wr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hready_q;
  logic hresp_q;
  logic [7:0] pins_q, pins_d;
  logic pwr_q, pwr_d;
  logic [2:0] pcr;
  logic go;
  logic mapped;

  conv_link_if link();

  conv_sequencer #(
    .CONV_TICKS(adc_pkg::CONV_TICKS)
  ) u_seq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .link(link.seq)
  );

  conv_clock_div #(
    .CNT_W(5)
  ) u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .link(link.div)
  );

  assign pcr = ctl_q[adc_pkg::CTL_PCR_LSB +: 3];
  assign link.start = ctl_q[adc_pkg::CTL_START_BIT];
  assign link.div_sel = csp_q[adc_pkg::CSP_DIV_LSB +: 3];
  // power follows the registers directly so a gated converter stops at once
  assign link.on = !csp_q[adc_pkg::CSP_PD_BIT] && (pcr != adc_pkg::PCR_NONE);

  // converter data only changes between conversions, so a plain double flop suffices
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sar_s1_q <= 12'h000;
      sar_s2_q <= 12'h000;
    end
    else
    begin
      sar_s1_q <= sar_data_i;
      sar_s2_q <= sar_s1_q;
    end
  end

  // bus address phase
  always_comb
  begin
    go = hsel_i && htrans_i[1] && hready_i;
    mapped = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'b00);
    wr_d = go && hwrite_i && mapped;
    waddr_d = go ? haddr_i[7:0] : waddr_q;
    hrdata_d = 32'h00000000;
    if (go && !hwrite_i && mapped)
    begin
      unique case (haddr_i[7:0])
        adc_pkg::OFF_RES_LOW:
        begin
          hrdata_d[7:0] = {res_q[3:0], 4'h0};
        end
        adc_pkg::OFF_RES_HIGH:
        begin
          hrdata_d[7:0] = res_q[11:4];
        end
        adc_pkg::OFF_CTRL:
        begin
          hrdata_d[7:0] = ctl_q;
          hrdata_d[adc_pkg::CTL_DONE_N_BIT] = link.eoc;
        end
        adc_pkg::OFF_CLK_PWR:
        begin
          hrdata_d[7:0] = csp_q;
        end
        adc_pkg::OFF_IRQ_STS:
        begin
          hrdata_d[0] = sts_q;
        end
        adc_pkg::OFF_IRQ_EN:
        begin
          hrdata_d[0] = ien_q;
        end
        default:
        begin
          hrdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // bus data phase and block state
  always_comb
  begin
    ctl_d = ctl_q;
    csp_d = csp_q;
    ien_d = ien_q;
    sts_d = sts_q;
    if (wr_q)
    begin
      unique case (waddr_q)
        adc_pkg::OFF_CTRL:
        begin
          ctl_d = hwdata_i[7:0] & adc_pkg::CTL_WR_MASK;
        end
        adc_pkg::OFF_CLK_PWR:
        begin
          csp_d = hwdata_i[7:0] & adc_pkg::CSP_WR_MASK;
        end
        adc_pkg::OFF_IRQ_CLR:
        begin
          if (hwdata_i[0])
          begin
            sts_d = 1'b0;
          end
        end
        adc_pkg::OFF_IRQ_EN:
        begin
          ien_d = hwdata_i[0];
        end
        default:
        begin
          ctl_d = ctl_q;
        end
      endcase
    end
    // a completion in the clearing cycle wins over the clear
    if (link.done)
    begin
      sts_d = 1'b1;
    end
    res_d = link.done ? sar_s2_q : res_q;
    irq_d = sts_d && ien_d;
    pwr_d = link.on;
    if (pcr == adc_pkg::PCR_NONE)
    begin
      pins_d = 8'h00;
    end
    else
    begin
      // pcr n frees pins 0..n; 111 makes all eight analog
      pins_d = 8'(8'hFF >> (adc_pkg::PCR_ALL - pcr));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctl_q <= adc_pkg::CTL_RESET;
      csp_q <= adc_pkg::CSP_RESET;
      res_q <= 12'h000;
      sts_q <= 1'b0;
      ien_q <= 1'b0;
      irq_q <= 1'b0;
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
      pins_q <= 8'h00;
      pwr_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      csp_q <= csp_d;
      res_q <= res_d;
      sts_q <= sts_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      hrdata_q <= hrdata_d;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
      pins_q <= pins_d;
      pwr_q <= pwr_d;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = hresp_q;
  assign channel_sel_o = ctl_q[adc_pkg::CTL_ACS_LSB +: 3];
  assign conv_power_o = pwr_q;
  assign conv_reset_o = link.conv_rst;
  assign conv_clk_o = link.conv_clk;
  assign analog_pin_en_o = pins_q;
  assign irq_o = irq_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_read(logic [7:0] off);
    go && !hwrite_i && haddr_i == {24'h000000, off};
  endsequence

  a_res_high_map: assert property (
    s_read(adc_pkg::OFF_RES_HIGH) |=> hrdata_o == {24'h000000, $past(res_q[11:4])})
    else $error("result high byte mapping wrong");
  a_res_low_map: assert property (
    s_read(adc_pkg::OFF_RES_LOW) |=> hrdata_o == {24'h000000, $past(res_q[3:0]), 4'h0})
    else $error("result low byte mapping wrong");
  a_channel_route: assert property (
    channel_sel_o == ctl_q[2:0] && $stable(channel_sel_o) || $past(wr_q))
    else $error("channel select changed without a write");
  a_all_pins_analog: assert property (
    pcr == adc_pkg::PCR_ALL |=> analog_pin_en_o == 8'hFF)
    else $error("pin config 111 did not free all pins");
  a_pins_digital: assert property (
    pcr == adc_pkg::PCR_NONE |=> analog_pin_en_o == 8'h00 && !conv_power_o)
    else $error("pin config zero left analog pins or power");
  a_power_gate: assert property (
    ##1 conv_power_o == $past(!csp_q[adc_pkg::CSP_PD_BIT] && pcr != adc_pkg::PCR_NONE))
    else $error("converter power does not follow gate");
  a_done_sets_flag: assert property (
    link.done |=> sts_q && res_q == $past(sar_s2_q) ##1 (irq_o == ien_q))
    else $error("completion did not set flag and result");
  a_result_holds: assert property (
    !link.done |=> $stable(res_q))
    else $error("result changed without completion");

  sequence s_write(logic [7:0] off);
    wr_q && waddr_q == off;
  endsequence

  // done_n is never taken from the bus, only the writable bits land
  a_ctl_write: assert property (
    s_write(adc_pkg::OFF_CTRL) |=> ctl_q == $past(hwdata_i[7:0] & adc_pkg::CTL_WR_MASK))
    else $error("control write did not land");
  a_csp_write: assert property (
    s_write(adc_pkg::OFF_CLK_PWR) |=> csp_q == $past(hwdata_i[7:0] & adc_pkg::CSP_WR_MASK))
    else $error("clock power write did not land");
  a_ien_write: assert property (
    s_write(adc_pkg::OFF_IRQ_EN) |=> ien_q == $past(hwdata_i[0]))
    else $error("interrupt enable write did not land");
  // a completion in the clearing cycle must leave the flag set
  a_irq_clear: assert property (
    s_write(adc_pkg::OFF_IRQ_CLR) ##0 hwdata_i[0] |=> sts_q == $past(link.done))
    else $error("interrupt clear handled wrong");
  a_irq_level: assert property (
    irq_o == (sts_q && ien_q))
    else $error("interrupt level does not follow enabled flag");
endmodule // adc_sequencing_control

// ===== bench/analog_source_model.sv
`timescale 1ns/1ps
// converter macro with its analog sources: one level per channel
module analog_source_model (
  // clock
  input wire logic mclk_i,
  // converter control
  input wire logic [2:0] channel_sel_i,
  input wire logic conv_power_i,
  input wire logic conv_reset_i,
  input wire logic [7:0][11:0] chan_vals_i,
  // result
  output logic [11:0] sar_data_o
);
  initial sar_data_o = 12'h000;
  // unpowered or held in reset: no valid result, so the lines keep toggling
  always @(posedge mclk_i)
  begin
    if (conv_power_i && !conv_reset_i)
      sar_data_o <= chan_vals_i[channel_sel_i];
    else
      sar_data_o <= ~sar_data_o;
  end
endmodule // analog_source_model

// ===== bench/adc_sequencing_control_tb.sv
`timescale 1ns/1ps
module adc_sequencing_control_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, conv_power_o, conv_reset_o, conv_clk_o, irq_o, clk_prev;
  logic [2:0] channel_sel_o;
  logic [7:0] analog_pin_en_o;
  logic [11:0] sar_data;
  logic [7:0][11:0] chan_vals = '0;
  int mismatches = 0;
  int cmp_count = 0;
  int ticks = 0;

  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    clk_prev <= conv_clk_o;
    if (conv_clk_o === 1'b1 && clk_prev === 1'b0)
      ticks <= ticks + 1;
  end

  adc_sequencing_control i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sar_data_i(sar_data),
    .channel_sel_o(channel_sel_o), .conv_power_o(conv_power_o),
    .conv_reset_o(conv_reset_o), .conv_clk_o(conv_clk_o),
    .analog_pin_en_o(analog_pin_en_o), .irq_o(irq_o));
  analog_source_model i_src (.mclk_i(mclk_i), .channel_sel_i(channel_sel_o),
    .conv_power_i(conv_power_o), .conv_reset_i(conv_reset_o),
    .chan_vals_i(chan_vals), .sar_data_o(sar_data));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single transfer; signals held until hready is seen high at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk_i);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do
    begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(what, exp, x);
  endtask

  function automatic int ratio(input logic [2:0] dv);
    return (dv == 3'h0) ? 2 : (dv == 3'h1) ? 8 : 32;
  endfunction

  function automatic logic [7:0] pin_mask(input logic [2:0] p);
    return (p == 3'h0) ? 8'h00 : (8'hFF >> (3'h7 - p));
  endfunction

  // start is raised in the same write that sets the channel, so the done flag is never stale
  task automatic convert(input logic [2:0] dv, input logic [2:0] ch, input logic en);
    int cyc, t0, n;
    logic [11:0] v;
    logic [31:0] x;
    n = ratio(dv);
    v = chan_vals[ch];
    wr(adc_pkg::OFF_IRQ_EN, {31'h0, en});
    wr(adc_pkg::OFF_CLK_PWR, {29'h0, dv});
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b10, 3'h7, ch});
    // the converter reset flop follows the control register one edge later
    @(posedge mclk_i);
    @(negedge mclk_i);
    check("channel_sel_o", {29'h0, ch}, {29'h0, channel_sel_o});
    check("conv_reset_o", 32'h1, {31'h0, conv_reset_o});
    rd_chk("done_n armed", adc_pkg::OFF_CTRL, {24'h0, 2'b11, 3'h7, ch});
    t0 = ticks;
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b00, 3'h7, ch});
    cyc = 0;
    if (en)
    begin
      while (irq_o !== 1'b1 && cyc < 700)
      begin
        @(posedge mclk_i);
        cyc++;
      end
      check("conv cycles ok", 32'h1, {31'h0, cyc >= 16 * n && cyc <= 16 * n + 8});
    end
    else
    begin
      x = 32'h40;
      while (x[6] !== 1'b0 && cyc < 200)
      begin
        bus(1'b0, adc_pkg::OFF_CTRL, 32'h0, x);
        cyc++;
      end
      check("irq_o masked", 32'h0, {31'h0, irq_o});
    end
    check("conv clk periods", 32'd16, ticks - t0);
    rd_chk("done_n end", adc_pkg::OFF_CTRL, {24'h0, 2'b00, 3'h7, ch});
    rd_chk("result high", adc_pkg::OFF_RES_HIGH, {24'h0, v[11:4]});
    rd_chk("result low", adc_pkg::OFF_RES_LOW, {24'h0, v[3:0], 4'h0});
    rd_chk("irq status", adc_pkg::OFF_IRQ_STS, 32'h1);
    wr(adc_pkg::OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk_i);
    check("irq_o cleared", 32'h0, {31'h0, irq_o});
    rd_chk("irq status clr", adc_pkg::OFF_IRQ_STS, 32'h0);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge mclk_i);
    mismatches++;
    complete_run();
  end

  initial
  begin
    int t0;
    logic [11:0] held;
    void'($urandom(82964));
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
      chan_vals[i] <= 12'($urandom());
    rd_chk("ctrl reset", adc_pkg::OFF_CTRL, 32'h40);
    rd_chk("clk_pwr reset", adc_pkg::OFF_CLK_PWR, 32'h80);
    rd_chk("unmapped", 8'h1C, 32'h0);
    // every pin config with power-down both ways
    for (int p = 0; p < 8; p++)
      for (int pd = 0; pd < 2; pd++)
      begin
        wr(adc_pkg::OFF_CLK_PWR, {24'h0, pd[0], 7'h01});
        wr(adc_pkg::OFF_CTRL, {24'h0, 2'b00, p[2:0], 3'h0});
        repeat (2) @(posedge mclk_i);
        check("pin_en", {24'h0, pin_mask(p[2:0])}, {24'h0, analog_pin_en_o});
        check("power", {31'h0, p != 0 && pd == 0}, {31'h0, conv_power_o});
      end
    // the channel sweep keeps the converter clock period legal at this system clock
    for (int c = 0; c < 8; c++)
      convert(3'h2, c[2:0], 1'b1);
    // /2 and /8 are too fast for the converter here; they prove the divider only
    convert(3'h0, 3'($urandom()), 1'b1);
    convert(3'h1, 3'($urandom()), 1'b1);
    convert(3'h2, 3'($urandom()), 1'b0);
    // result must hold while the source moves
    held = chan_vals[channel_sel_o];
    chan_vals <= {4{24'($urandom())}};
    repeat (5) @(posedge mclk_i);
    rd_chk("held high", adc_pkg::OFF_RES_HIGH, {24'h0, held[11:4]});
    // abort in mid conversion
    convert(3'h1, 3'h5, 1'b1);
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b10, 3'h7, 3'h5});
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b00, 3'h7, 3'h5});
    repeat (40) @(posedge mclk_i);
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b10, 3'h7, 3'h5});
    @(posedge mclk_i);
    @(negedge mclk_i);
    check("abort reset", 32'h1, {31'h0, conv_reset_o});
    rd_chk("abort done_n", adc_pkg::OFF_CTRL, 32'hFD);
    // undefined divider gives no conversion clock
    wr(adc_pkg::OFF_CLK_PWR, 32'h03);
    t0 = ticks;
    wr(adc_pkg::OFF_CTRL, {24'h0, 2'b00, 3'h7, 3'h5});
    repeat (100) @(posedge mclk_i);
    check("undef div ticks", 32'h0, ticks - t0);
    rd_chk("undef done_n", adc_pkg::OFF_CTRL, 32'h7D);
    convert(3'h0, 3'h2, 1'b1);
    complete_run();
  end
endmodule // adc_sequencing_control_tb
